// [brf_params.svh]
// Constants for the breaker failure supervision block: offsets, fields, resets and timing.
// Assumes inclusion by the block's top module only.
`ifndef BRF_PARAMS_SVH
`define BRF_PARAMS_SVH

// Register word indices; the byte address is four times the index.
`define BRF_IDX_CTRL     3'h0
`define BRF_IDX_PH_THR   3'h1
`define BRF_IDX_RES_THR  3'h2
`define BRF_IDX_BU_DLY   3'h3
`define BRF_IDX_RT_DLY   3'h4
`define BRF_IDX_PULSE    3'h5
`define BRF_IDX_STATUS   3'h6

// Control register fields.
`define BRF_CTRL_MODE_LSB 0
`define BRF_CTRL_RT_EN    2
`define BRF_CTRL_SP       3

// Reset values of the settings.
`define BRF_RST_PH_THR   16'h001E
`define BRF_RST_RES_THR  16'h0014
`define BRF_RST_BU_DLY   16'h03E8
`define BRF_RST_RT_DLY   16'h0064
`define BRF_RST_PULSE    16'h0064

// Setting limits in milliseconds.
`define BRF_BU_MIN       16'h0064
`define BRF_BU_MAX       16'hEA60
`define BRF_RT_MAX       16'h03E8
`define BRF_PULSE_MAX    16'hEA60

// Timebase: clock rate and tick period.
`define BRF_CLK_MHZ      250
`define BRF_TICK_US      1000
`define BRF_MS_CYCLES    (`BRF_CLK_MHZ * `BRF_TICK_US)

`endif

// [brf_pkg.sv]
// Types shared by the breaker failure supervision block.
// Assumes nothing beyond a SystemVerilog compiler.
package brf_pkg;

  // Operation setting.
  typedef enum logic [1:0] {
    BRF_OFF,
    BRF_CURRENT,
    BRF_CONTACT,
    BRF_BOTH
  } brf_mode_e;

  // Software settings held by the register file.
  typedef struct packed {
    brf_mode_e   mode;
    logic        retrip_en;
    logic        single_pole;
    logic [15:0] ph_thr;
    logic [15:0] res_thr;
    logic [15:0] bu_dly;
    logic [15:0] rt_dly;
    logic [15:0] pulse;
  } brf_cfg_s;

endpackage : brf_pkg

// [brf_top.sv]
// Breaker failure supervision: start timers, fault checks, trip pulses, Avalon-MM registers.
// Assumes all binary and current inputs come from logic on core_clk.
//
// The address map and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
`include "brf_params.svh"

module brf_top #(
  parameter int MS_CYCLES = `BRF_MS_CYCLES
) (
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // Avalon-MM slave, word addressed.
  input  wire logic [2:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Start, block and breaker status from trip logic.
  input  wire logic        block_in,
  input  wire logic        common_start_in,
  input  wire logic        start_ph1_in,
  input  wire logic        start_ph2_in,
  input  wire logic        start_ph3_in,
  input  wire logic        residual_start_in,
  input  wire logic        breaker_closed_in,
  input  wire logic        breaker_closed_ph1_in,
  input  wire logic        breaker_closed_ph2_in,
  input  wire logic        breaker_closed_ph3_in,
  // Current magnitudes in percent of nominal.
  input  wire logic [15:0] ph1_current,
  input  wire logic [15:0] ph2_current,
  input  wire logic [15:0] ph3_current,
  input  wire logic [15:0] residual_current,
  // Trip commands.
  output logic             backup_trip_out,
  output logic             retrip_ph1_out,
  output logic             retrip_ph2_out,
  output logic             retrip_ph3_out
);

  // Channels 0..2 are the phases, channel 3 is the residual path.
  localparam int NCH = 4;

  brf_pkg::brf_cfg_s cfg;
  logic              ack;
  logic [17:0]       tick_cnt;
  logic              tick;
  logic [NCH-1:0]    start_now;
  logic [NCH-1:0]    start_q;
  logic [NCH-1:0]    over;
  logic [NCH-1:0]    closed;
  logic [NCH-1:0]    fault;
  logic [NCH-1:0]    active;
  logic [15:0]       bu_cnt [NCH];
  logic [15:0]       rt_cnt [NCH];
  logic [NCH-1:0]    bu_exp;
  logic [2:0]        rt_exp;
  logic              enabled;
  logic [15:0]       pcnt [NCH];
  logic [NCH-1:0]    trip;
  logic [NCH-1:0]    cause;

  // Clamp a written value into a setting's range.
  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
                                        input logic [15:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp

  // Strict comparison used by every overcurrent flag.
  function automatic logic exceeds(input logic [15:0] i, input logic [15:0] thr);
    exceeds = (i > thr);
  endfunction : exceeds

  // One wait state on every access: the answer is registered and the bus sees it a cycle later.
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read | avs_write) & ~ack;
    end
  end

  // Settings registers; writes land on the edge where waitrequest is low.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cfg.mode        <= brf_pkg::BRF_OFF;
      cfg.retrip_en   <= 1'b0;
      cfg.single_pole <= 1'b0;
      cfg.ph_thr      <= `BRF_RST_PH_THR;
      cfg.res_thr     <= `BRF_RST_RES_THR;
      cfg.bu_dly      <= `BRF_RST_BU_DLY;
      cfg.rt_dly      <= `BRF_RST_RT_DLY;
      cfg.pulse       <= `BRF_RST_PULSE;
    end else if (avs_write && ack) begin
      unique case (avs_address)
        `BRF_IDX_CTRL: begin
          cfg.mode        <= brf_pkg::brf_mode_e'(avs_writedata[`BRF_CTRL_MODE_LSB +: 2]);
          cfg.retrip_en   <= avs_writedata[`BRF_CTRL_RT_EN];
          cfg.single_pole <= avs_writedata[`BRF_CTRL_SP];
        end
        `BRF_IDX_PH_THR:  cfg.ph_thr  <= avs_writedata[15:0];
        `BRF_IDX_RES_THR: cfg.res_thr <= avs_writedata[15:0];
        // Out-of-range delays are pulled to the nearest limit.
        `BRF_IDX_BU_DLY:  cfg.bu_dly <= clamp(avs_writedata[15:0], `BRF_BU_MIN,
                                              `BRF_BU_MAX);
        `BRF_IDX_RT_DLY:  cfg.rt_dly <= clamp(avs_writedata[15:0], 16'h0000,
                                              `BRF_RT_MAX);
        `BRF_IDX_PULSE:   cfg.pulse  <= clamp(avs_writedata[15:0], 16'h0000,
                                              `BRF_PULSE_MAX);
        default: ;
      endcase
    end
  end

  // Read data; status shows running timers and trip outputs, unmapped words read zero.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack) begin
      unique case (avs_address)
        `BRF_IDX_CTRL:    avs_readdata <= {28'h000_0000, cfg.single_pole, cfg.retrip_en,
                                           cfg.mode};
        `BRF_IDX_PH_THR:  avs_readdata <= {16'h0000, cfg.ph_thr};
        `BRF_IDX_RES_THR: avs_readdata <= {16'h0000, cfg.res_thr};
        `BRF_IDX_BU_DLY:  avs_readdata <= {16'h0000, cfg.bu_dly};
        `BRF_IDX_RT_DLY:  avs_readdata <= {16'h0000, cfg.rt_dly};
        `BRF_IDX_PULSE:   avs_readdata <= {16'h0000, cfg.pulse};
        `BRF_IDX_STATUS:  avs_readdata <= {24'h00_0000, trip, active};
        default:          avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // Millisecond timebase shared by all timers.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tick_cnt <= 18'h0_0000;
    end else if (tick_cnt == 18'(MS_CYCLES - 1)) begin
      tick_cnt <= 18'h0_0000;
    end else begin
      tick_cnt <= tick_cnt + 18'h0_0001;
    end
  end

  assign tick = (tick_cnt == 18'(MS_CYCLES - 1));

  // Block and the off setting stop everything.
  assign enabled = (cfg.mode != brf_pkg::BRF_OFF) && !block_in;

  // Start selection: the single-pole variant uses phase starts, the common one the general start.
  assign start_now[0] = cfg.single_pole ? start_ph1_in : common_start_in;
  assign start_now[1] = cfg.single_pole ? start_ph2_in : common_start_in;
  assign start_now[2] = cfg.single_pole ? start_ph3_in : common_start_in;
  assign start_now[3] = residual_start_in;

  // Overcurrent flags for each phase and the residual path.
  assign over[0] = exceeds(ph1_current, cfg.ph_thr);
  assign over[1] = exceeds(ph2_current, cfg.ph_thr);
  assign over[2] = exceeds(ph3_current, cfg.ph_thr);
  assign over[3] = exceeds(residual_current, cfg.res_thr);

  // Breaker-closed status: per phase in single-pole, one common input otherwise.
  assign closed[0] = cfg.single_pole ? breaker_closed_ph1_in : breaker_closed_in;
  assign closed[1] = cfg.single_pole ? breaker_closed_ph2_in : breaker_closed_in;
  assign closed[2] = cfg.single_pole ? breaker_closed_ph3_in : breaker_closed_in;
  assign closed[3] = cfg.single_pole ? |closed[2:0] : breaker_closed_in;

  // Fault persistence per channel according to the operation setting.
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      unique case (cfg.mode)
        brf_pkg::BRF_CURRENT: fault[c] = over[c];
        brf_pkg::BRF_CONTACT: fault[c] = closed[c];
        brf_pkg::BRF_BOTH:    fault[c] = over[c] | closed[c];
        brf_pkg::BRF_OFF:     fault[c] = 1'b0;
      endcase
    end
  end

  // Previous start level for edge detection.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      start_q <= '0;
    end else begin
      start_q <= start_now;
    end
  end

  // Per-channel timers. A timer only starts on a rising start edge, so a start held high
  // through a block does not relaunch when the block drops.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      active <= '0;
      for (int c = 0; c < NCH; c++) begin
        bu_cnt[c] <= 16'h0000;
        rt_cnt[c] <= 16'h0000;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (!enabled || !start_now[c] || !fault[c]) begin
          active[c] <= 1'b0;
          bu_cnt[c] <= 16'h0000;
          rt_cnt[c] <= 16'h0000;
        end else if (start_now[c] && !start_q[c]) begin
          active[c] <= 1'b1;
          bu_cnt[c] <= 16'h0000;
          rt_cnt[c] <= 16'h0000;
        end else if (active[c] && tick) begin
          if (bu_cnt[c] != 16'hFFFF) begin
            bu_cnt[c] <= bu_cnt[c] + 16'h0001;
          end
          if (rt_cnt[c] != 16'hFFFF) begin
            rt_cnt[c] <= rt_cnt[c] + 16'h0001;
          end
        end
      end
    end
  end

  // Expiry flags: they hold while the timer runs past its delay with the fault present.
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      bu_exp[c] = active[c] && (bu_cnt[c] >= cfg.bu_dly);
    end
    for (int c = 0; c < 3; c++) begin
      rt_exp[c] = active[c] && (rt_cnt[c] >= cfg.rt_dly) && cfg.retrip_en
                  && cfg.single_pole;
    end
  end

  // Trip causes: index 0 is backup, 1..3 the phase retrips.
  assign cause = {rt_exp, |bu_exp};

  // Trip outputs with minimum pulse length counted from the last moment the cause held.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      trip <= '0;
      for (int k = 0; k < NCH; k++) begin
        pcnt[k] <= 16'h0000;
      end
    end else begin
      for (int k = 0; k < NCH; k++) begin
        if (!enabled) begin
          trip[k] <= 1'b0;
          pcnt[k] <= 16'h0000;
        end else if (cause[k]) begin
          trip[k] <= 1'b1;
          pcnt[k] <= 16'h0000;
        end else if (trip[k] && tick) begin
          if (pcnt[k] >= cfg.pulse) begin
            trip[k] <= 1'b0;
          end else begin
            pcnt[k] <= pcnt[k] + 16'h0001;
          end
        end
      end
    end
  end

  // Retrip outputs exist only in the single-pole variant; cause already gates them.
  assign backup_trip_out = trip[0];
  assign retrip_ph1_out  = trip[1];
  assign retrip_ph2_out  = trip[2];
  assign retrip_ph3_out  = trip[3];

  // With the function off, no trip stands a cycle later.
  property p_off_quiet;
    @(posedge core_clk) disable iff (sys_rst)
      (cfg.mode == brf_pkg::BRF_OFF) |=> (trip == '0);
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("trip present while operation is off");

  // Block drops outputs and timers on the next edge.
  property p_block;
    @(posedge core_clk) disable iff (sys_rst)
      block_in |=> (trip == '0) && (active == '0);
  endproperty
  a_block: assert property (p_block)
    else $error("activity while blocked");

  // A qualified rising start launches the phase 1 timer.
  property p_launch;
    @(posedge core_clk) disable iff (sys_rst)
      (enabled && start_now[0] && !start_q[0] && fault[0])
        |=> active[0] && (bu_cnt[0] == 16'h0000);
  endproperty
  a_launch: assert property (p_launch)
    else $error("timer did not launch on start edge");

  // A falling start clears a running timer.
  property p_start_fall;
    @(posedge core_clk) disable iff (sys_rst)
      (active[1] && !start_now[1]) |=> !active[1];
  endproperty
  a_start_fall: assert property (p_start_fall)
    else $error("timer kept running after start fell");

  // Current mode looks only at overcurrent.
  property p_current_mode;
    @(posedge core_clk) disable iff (sys_rst)
      (cfg.mode == brf_pkg::BRF_CURRENT && active[0] && !over[0] && closed[0])
        |=> !active[0];
  endproperty
  a_current_mode: assert property (p_current_mode)
    else $error("current mode followed breaker contact");

  // Contact mode looks only at breaker status.
  property p_contact_mode;
    @(posedge core_clk) disable iff (sys_rst)
      (cfg.mode == brf_pkg::BRF_CONTACT && active[2] && over[2] && !closed[2])
        |=> !active[2];
  endproperty
  a_contact_mode: assert property (p_contact_mode)
    else $error("contact mode followed current");

  // Combined mode holds while either criterion persists.
  property p_both_mode;
    @(posedge core_clk) disable iff (sys_rst)
      (cfg.mode == brf_pkg::BRF_BOTH && enabled && active[0] && start_now[0]
       && (over[0] || closed[0]) && !tick) |=> active[0];
  endproperty
  a_both_mode: assert property (p_both_mode)
    else $error("combined mode reset with a fault present");

  // Backup trip rises only after a backup timer expired.
  property p_backup_cause;
    @(posedge core_clk) disable iff (sys_rst)
      $rose(backup_trip_out) |-> $past(|bu_exp);
  endproperty
  a_backup_cause: assert property (p_backup_cause)
    else $error("backup trip without timer expiry");

  // Retrip rises only when retrip is enabled in the single-pole variant.
  property p_retrip_en;
    @(posedge core_clk) disable iff (sys_rst)
      $rose(retrip_ph1_out) |-> $past(cfg.retrip_en && cfg.single_pole && rt_exp[0]);
  endproperty
  a_retrip_en: assert property (p_retrip_en)
    else $error("retrip without enable");

  // A trip falls only after its pulse count reached the setting, or on disable or reset.
  // The reset term matters on the edge that releases reset, where the attempt is not disabled.
  property p_pulse_min;
    @(posedge core_clk) disable iff (sys_rst)
      $fell(backup_trip_out) |-> $past((tick && pcnt[0] >= cfg.pulse) || !enabled || sys_rst);
  endproperty
  a_pulse_min: assert property (p_pulse_min)
    else $error("trip pulse shorter than setting");

endmodule : brf_top

// [brf_field_model.sv]
// Partner model: the trip logic and breaker contacts that feed the supervision block.
// Assumes the bench sets wanted levels on core_clk; every output is registered.
`timescale 1ns/1ps
module brf_field_model (
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // Wanted levels from the bench.
  input  wire logic        want_block,
  input  wire logic [4:0]  want_start,
  input  wire logic [3:0]  want_closed,
  input  wire logic [3:0]  want_amps,
  // Levels toward the block.
  output logic             block_in,
  output logic [4:0]       start_lvl,
  output logic [3:0]       closed_lvl,
  output logic [3:0][15:0] amps
);

  // Registered so each change lands just after an edge, as real logic would.
  // A quiet channel sits exactly on its reset threshold, which must not count as over.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      block_in   <= 1'b0;
      start_lvl  <= 5'h00;
      closed_lvl <= 4'h0;
      amps       <= '0;
    end else begin
      block_in   <= want_block;
      start_lvl  <= want_start;
      closed_lvl <= want_closed;
      for (int i = 0; i < 4; i++) begin
        amps[i] <= want_amps[i] ? 16'h0064 : ((i < 3) ? 16'h001E : 16'h0014);
      end
    end
  end

endmodule : brf_field_model

// [brf_top_tb.sv]
// Self-checking bench for the breaker failure supervision block.
// Assumes brf_top with a short millisecond tick and the field model as partner.
`timescale 1ns/1ps
module brf_top_tb;
  localparam int MS = 4;
  logic             core_clk      = 1'b0;
  logic             sys_rst       = 1'b1;
  logic [2:0]       avs_address   = 3'h0;
  logic             avs_read      = 1'b0;
  logic             avs_write     = 1'b0;
  logic [31:0]      avs_writedata = 32'h0000_0000;
  logic [31:0]      avs_readdata;
  logic             avs_waitrequest;
  logic             want_block    = 1'b0;
  logic [4:0]       want_start    = 5'h00;
  logic [3:0]       want_closed   = 4'h0;
  logic [3:0]       want_amps     = 4'h0;
  logic             block_in;
  logic [4:0]       start_lvl;
  logic [3:0]       closed_lvl;
  logic [3:0][15:0] amps;
  logic [3:0]       trips;
  logic [31:0]      rd;
  int               bad_count     = 0;
  int               total_checks  = 0;

  // Clock of 4 ns period.
  always #2 core_clk = ~core_clk;

  brf_field_model model (.core_clk(core_clk), .sys_rst(sys_rst), .want_block(want_block),
    .want_start(want_start), .want_closed(want_closed), .want_amps(want_amps),
    .block_in(block_in), .start_lvl(start_lvl), .closed_lvl(closed_lvl), .amps(amps));

  // Trips are gathered as {retrip ph3, ph2, ph1, backup}.
  brf_top #(.MS_CYCLES(MS)) uut (.core_clk(core_clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .block_in(block_in),
    .common_start_in(start_lvl[0]), .start_ph1_in(start_lvl[1]),
    .start_ph2_in(start_lvl[2]), .start_ph3_in(start_lvl[3]),
    .residual_start_in(start_lvl[4]), .breaker_closed_in(closed_lvl[0]),
    .breaker_closed_ph1_in(closed_lvl[1]), .breaker_closed_ph2_in(closed_lvl[2]),
    .breaker_closed_ph3_in(closed_lvl[3]), .ph1_current(amps[0]), .ph2_current(amps[1]),
    .ph3_current(amps[2]), .residual_current(amps[3]), .backup_trip_out(trips[0]),
    .retrip_ph1_out(trips[1]), .retrip_ph2_out(trips[2]), .retrip_ph3_out(trips[3]));

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict

  // Case equality, so an unknown never passes.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One Avalon cycle; the request is held until waitrequest is sampled low at a rising edge.
  task automatic av_cycle(input logic wr, input logic [2:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) begin
      bad_count++;
      give_verdict();
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : av_cycle

  task automatic read_chk(input logic [2:0] a, input logic [31:0] exp);
    av_cycle(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask : read_chk

  // Waits whole ticks, then settles on a falling edge for sampling.
  task automatic wait_ms(input int n);
    repeat (n * MS) @(posedge core_clk);
    @(negedge core_clk);
  endtask : wait_ms

  task automatic set_in(input logic b, input logic [4:0] s, input logic [3:0] c,
                        input logic [3:0] m);
    @(posedge core_clk);
    want_block  <= b;
    want_start  <= s;
    want_closed <= c;
    want_amps   <= m;
  endtask : set_in

  // Launch, look before and after the 100 ms backup expiry, then watch the pulse tail.
  task automatic trial(input logic [31:0] ctrl, input logic b, input logic [4:0] s,
                       input logic [3:0] c, input logic [3:0] m,
                       input logic [3:0] pre, input logic [3:0] post);
    av_cycle(1'b1, 3'h0, ctrl);
    set_in(b, s, c, m);
    wait_ms(98);
    check(trips, pre);
    wait_ms(3);
    check(trips, post);
    set_in(1'b0, 5'h00, 4'h0, 4'h0);
    wait_ms(3);
    check(trips, post);
    wait_ms(9);
    check(trips, 4'h0);
  endtask : trial

  task automatic t_regs;
    read_chk(3'h0, 32'h0000_0000);
    read_chk(3'h1, 32'h0000_001E);
    read_chk(3'h2, 32'h0000_0014);
    read_chk(3'h3, 32'h0000_03E8);
    read_chk(3'h4, 32'h0000_0064);
    read_chk(3'h5, 32'h0000_0064);
    av_cycle(1'b1, 3'h3, 32'h0000_0032);
    read_chk(3'h3, 32'h0000_0064);
    av_cycle(1'b1, 3'h3, 32'h0000_EA61);
    read_chk(3'h3, 32'h0000_EA60);
    av_cycle(1'b1, 3'h4, 32'h0000_03E9);
    read_chk(3'h4, 32'h0000_03E8);
    av_cycle(1'b1, 3'h4, 32'h0000_0000);
    read_chk(3'h4, 32'h0000_0000);
    av_cycle(1'b1, 3'h5, 32'h0000_FFFF);
    read_chk(3'h5, 32'h0000_EA60);
    av_cycle(1'b1, 3'h7, 32'hFFFF_FFFF);
    read_chk(3'h7, 32'h0000_0000);
    av_cycle(1'b1, 3'h6, 32'h0000_00FF);
    read_chk(3'h6, 32'h0000_0000);
    // Short retrip and pulse keep the run brief; backup stays at its floor.
    av_cycle(1'b1, 3'h3, 32'h0000_0064);
    av_cycle(1'b1, 3'h4, 32'h0000_000A);
    av_cycle(1'b1, 3'h5, 32'h0000_0005);
  endtask : t_regs

  task automatic t_modes;
    trial(32'h0, 1'b0, 5'h01, 4'h1, 4'h1, 4'h0, 4'h0);
    trial(32'h1, 1'b0, 5'h01, 4'h0, 4'h1, 4'h0, 4'h1);
    trial(32'h1, 1'b0, 5'h01, 4'h1, 4'h0, 4'h0, 4'h0);
    trial(32'h2, 1'b0, 5'h01, 4'h0, 4'h1, 4'h0, 4'h0);
    trial(32'h2, 1'b0, 5'h01, 4'h1, 4'h0, 4'h0, 4'h1);
    trial(32'h3, 1'b0, 5'h01, 4'h1, 4'h0, 4'h0, 4'h1);
    trial(32'h3, 1'b1, 5'h01, 4'h1, 4'h1, 4'h0, 4'h0);
    trial(32'h1, 1'b0, 5'h10, 4'h0, 4'h8, 4'h0, 4'h1);
    trial(32'h1, 1'b0, 5'h10, 4'h0, 4'h7, 4'h0, 4'h0);
  endtask : t_modes

  task automatic t_single_pole;
    trial(32'h9, 1'b0, 5'h02, 4'h0, 4'h1, 4'h0, 4'h1);
    trial(32'h9, 1'b0, 5'h01, 4'h0, 4'h1, 4'h0, 4'h0);
    trial(32'hD, 1'b0, 5'h04, 4'h0, 4'h2, 4'h4, 4'h5);
    trial(32'hE, 1'b0, 5'h08, 4'h8, 4'h0, 4'h8, 4'h9);
    trial(32'h5, 1'b0, 5'h01, 4'h0, 4'h1, 4'h0, 4'h1);
  endtask : t_single_pole

  // Start falls, then a relaunch goes fault-free; neither may trip.
  task automatic t_fall;
    av_cycle(1'b1, 3'h0, 32'h0000_0001);
    set_in(1'b0, 5'h01, 4'h0, 4'h1);
    wait_ms(50);
    set_in(1'b0, 5'h00, 4'h0, 4'h1);
    wait_ms(60);
    check(trips, 4'h0);
    set_in(1'b0, 5'h01, 4'h1, 4'h1);
    wait_ms(50);
    set_in(1'b0, 5'h01, 4'h1, 4'h0);
    wait_ms(55);
    check(trips, 4'h0);
    // Contact mode, phase 3: the breaker opens while current stays high.
    av_cycle(1'b1, 3'h0, 32'h0000_000A);
    set_in(1'b0, 5'h08, 4'h8, 4'h4);
    wait_ms(50);
    set_in(1'b0, 5'h08, 4'h0, 4'h4);
    wait_ms(55);
    check(trips, 4'h0);
    set_in(1'b0, 5'h00, 4'h0, 4'h0);
  endtask : t_fall

  // Timer activity of phase 2 and its retrip show in the status word.
  task automatic t_status;
    av_cycle(1'b1, 3'h0, 32'h0000_000D);
    set_in(1'b0, 5'h04, 4'h0, 4'h2);
    wait_ms(50);
    read_chk(3'h6, 32'h0000_0042);
    set_in(1'b0, 5'h00, 4'h0, 4'h0);
    wait_ms(12);
  endtask : t_status

  // A reset in mid-trip drops the trip and returns the mode to off.
  task automatic t_reset;
    av_cycle(1'b1, 3'h0, 32'h0000_0001);
    set_in(1'b0, 5'h01, 4'h0, 4'h1);
    wait_ms(101);
    check(trips, 4'h1);
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(negedge core_clk);
    check(trips, 4'h0);
    read_chk(3'h0, 32'h0000_0000);
  endtask : t_reset

  // Main sequence after eight cycles of reset.
  initial begin
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_regs();
    t_modes();
    t_single_pole();
    t_fall();
    t_status();
    t_reset();
    give_verdict();
  end

  // Cuts a hang short.
  initial begin
    repeat (100000) @(posedge core_clk);
    bad_count++;
    give_verdict();
  end

endmodule : brf_top_tb
